/* hdl/pcp_pkg.sv */
// Constants, register map and field positions for the dual port pin controller.
// Assumes a 32-bit APB master and a 20 MHz pclk.
package pcp_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_P2_DATA  = 8'h00;
	localparam logic [7:0] OFF_P2_DIR   = 8'h04;
	localparam logic [7:0] OFF_P2_PINS  = 8'h08;
	localparam logic [7:0] OFF_P3_MODE  = 8'h0C;
	localparam logic [7:0] OFF_PCFG     = 8'h10;
	localparam logic [7:0] OFF_IRQ_REQ  = 8'h14;
	localparam logic [7:0] OFF_INT_STAT = 8'h18;
	localparam logic [7:0] OFF_INT_MASK = 8'h1C;
	localparam logic [7:0] OFF_P3_DATA  = 8'h20;
	localparam logic [7:0] OFF_P3_PINS  = 8'h24;
	localparam logic [7:0] OFF_SER_CTRL = 8'h28;
	localparam logic [7:0] OFF_SMR      = 8'h2C;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int P3M_OPEN_DRAIN = 0;
	localparam int P3M_ANALOG     = 1;
	localparam int PCFG_CMP_OUT   = 0;
	localparam int PCFG_EMI_P2    = 1;
	localparam int PCFG_EMI_P3    = 2;
	localparam int PCFG_EMI_OSC   = 3;
	localparam int IRQ_EDGE_LO    = 6;
	localparam int IRQ_EDGE_HI    = 7;
	localparam int SER_ENABLE     = 0;
	localparam int SER_SLAVE      = 1;
	localparam int SER_TMR_OUT    = 2;
	localparam int SMR_EXT_CLK    = 1;
	localparam int INT_P32        = 0;
	localparam int INT_P33        = 1;
	localparam int INT_P31        = 2;

	// ----------------------------------------------------------------
	// Widths and reset values
	// ----------------------------------------------------------------
	localparam int P2_W  = 8;
	localparam int P3_W  = 3;
	localparam int INT_W = 3;
	localparam logic [7:0]       RST_BYTE = 8'h00;
	localparam logic [P3_W-1:0]  RST_P3   = 3'h0;
	localparam logic [INT_W-1:0] RST_INT  = 3'h0;

	// Edge selection held in interrupt_request_reg bits 7:6
	typedef enum logic [1:0] {
		PCP_EDGE_FALL = 2'h0,
		PCP_EDGE_RISE = 2'h1,
		PCP_EDGE_BOTH = 2'h2,
		PCP_EDGE_ANY  = 2'h3
	} pcp_edge_t;

endpackage

/* hdl/pcp_evt_if.sv */
// Interface carrying one sampled line and its edge pulses.
// Assumes the edge detector and its user share pclk.
`timescale 1ns/10ps
`default_nettype none
interface pcp_evt_if;
	logic lvl;
	logic rise;
	logic fall;
	modport det (input lvl, output rise, output fall);
	modport usr (output lvl, input rise, input fall);
endinterface
`default_nettype wire

/* hdl/pcp_keeper.sv */
// Keeper latches holding the last driven level of undriven inputs.
// Assumes pin levels are synchronous to pclk.
`timescale 1ns/10ps
`default_nettype none
module pcp_keeper #(
	parameter int W = 8
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] pin,
	input  wire logic [W-1:0] driven,
	output var  logic [W-1:0] held_r
);
	// ----------------------------------------------------------------
	// Hold last driven level per line
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			held_r <= '0;
		end else begin
			for (int i = 0; i < W; i++) begin
				if (driven[i]) begin
					held_r[i] <= pin[i];
				end
			end
		end
	end
endmodule
`default_nettype wire

/* hdl/pcp_edge.sv */
// Edge detector for one interrupt line.
// Assumes the level is already synchronous to pclk.
`timescale 1ns/10ps
`default_nettype none
module pcp_edge (
	input  wire logic pclk,
	input  wire logic presetn,
	pcp_evt_if.det    ev
);
	logic prev_r;

	// ----------------------------------------------------------------
	// Previous level
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_r <= 1'b0;
		end else begin
			prev_r <= ev.lvl;
		end
	end

	assign ev.rise = ev.lvl & ~prev_r;
	assign ev.fall = ~ev.lvl & prev_r;
endmodule
`default_nettype wire

/* hdl/pcp_top.sv */
// Pin control for an 8-line bidirectional port and a 6-line fixed port.
// Assumes an APB master on pclk, external comparators and a serial block.
//
// How it works
// - Each port 2 line has its own direction bit, output or input.
// - One global bit makes all port 2 outputs push-pull or open-drain.
// - Undriven inputs keep a held level, except the three port 3 inputs.
// - Serial enabled: port 2 bit 0 is data in, bit 7 data out.
// - Port 3 has three fixed inputs without keepers, three push-pull outputs.
// - Analog mode: bits 1,2 feed comparators, bit 3 is the reference.
// - Port 3 bits 1,2 interrupt on falling, rising or both edges.
// - Port 3 bit 3 interrupts on falling edge only, digital mode only.
// - Bits 1,2 interrupt in both modes; bit 1 also feeds the timer.
// - Config bit D0 set routes comparator outputs to port 3 bits 4,5.
// - Timer 1 takes input from port 3 bit 1, outputs on bit 6.
// - Serial enabled: bit 4 is serial clock, bit 5 slave select when slave.
// - Low emission selectable for oscillator and each port separately.
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module pcp_top (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [7:0]  p2_in,
	input  wire logic [7:0]  p2_ext_drv,
	output var  logic [7:0]  p2_out,
	output var  logic [7:0]  p2_oe_n,
	input  wire logic [2:0]  p3_in,
	input  wire logic        p3_bit4_in,
	input  wire logic        p3_bit5_in,
	output var  logic [2:0]  p3_out,
	output var  logic [1:0]  p3_oe_n,
	input  wire logic [1:0]  cmp_out,
	output logic             cmp_enable,
	input  wire logic        serial_data_out,
	input  wire logic        serial_clock_out,
	output var  logic        serial_data_in,
	output var  logic        serial_clock_in,
	output var  logic        slave_select,
	output logic             serial_enable,
	output logic             serial_slave,
	input  wire logic        timer_output_pin,
	output logic             timer_input_pin,
	output logic             ext_falling_int_1,
	output logic             low_emi_port2,
	output logic             low_emi_port3,
	output logic             low_emi_osc,
	output logic             ext_clock_sel,
	output logic             irq
);
	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [7:0]              p2_data_r;
	logic [7:0]              p2_dir_r;
	logic [7:0]              p3_mode_r;
	logic [7:0]              pcfg_r;
	logic [7:0]              irq_req_r;
	logic [7:0]              ser_ctrl_r;
	logic [7:0]              smr_r;
	logic [pcp_pkg::P3_W-1:0]  p3_data_r;
	logic [pcp_pkg::INT_W-1:0] int_stat_r;
	logic [pcp_pkg::INT_W-1:0] int_stat_nxt;
	logic [pcp_pkg::INT_W-1:0] int_mask_r;
	logic [pcp_pkg::P3_W-1:0]  p3_smp_r;
	logic [7:0]              p2_held;
	logic [7:0]              p2_pin_val;
	logic [7:0]              p2_drv_mine;
	logic [7:0]              rd_val;
	logic                    rd_ok;
	logic                    wr_en;
	logic                    setup;
	logic                    analog;
	logic                    open_drain;
	logic                    ser_en;
	logic                    ser_slv;
	logic [1:0]              edge_sel;
	logic [2:0]              evt;
	logic [7:0]              p2_out_nxt;
	logic [7:0]              p2_oe_n_nxt;
	logic [2:0]              p3_out_nxt;
	logic [1:0]              p3_oe_n_nxt;

	pcp_evt_if ev31 ();
	pcp_evt_if ev32 ();
	pcp_evt_if ev33 ();

	assign setup      = psel & ~penable;
	assign wr_en      = psel & penable & pwrite;
	assign analog     = p3_mode_r[pcp_pkg::P3M_ANALOG];
	assign open_drain = p3_mode_r[pcp_pkg::P3M_OPEN_DRAIN];
	assign ser_en     = ser_ctrl_r[pcp_pkg::SER_ENABLE];
	assign ser_slv    = ser_ctrl_r[pcp_pkg::SER_SLAVE];
	assign edge_sel   = irq_req_r[pcp_pkg::IRQ_EDGE_HI:pcp_pkg::IRQ_EDGE_LO];

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~rd_ok;

	always_comb begin
		rd_ok  = 1'b1;
		rd_val = pcp_pkg::RST_BYTE;
		case (paddr[7:0])
			pcp_pkg::OFF_P2_DATA:  rd_val = p2_data_r;
			pcp_pkg::OFF_P2_DIR:   rd_val = p2_dir_r;
			pcp_pkg::OFF_P2_PINS:  rd_val = p2_held;
			pcp_pkg::OFF_P3_MODE:  rd_val = p3_mode_r;
			pcp_pkg::OFF_PCFG:     rd_val = pcfg_r;
			pcp_pkg::OFF_IRQ_REQ:  rd_val = irq_req_r;
			pcp_pkg::OFF_INT_STAT: rd_val = {5'h00, int_stat_r};
			pcp_pkg::OFF_INT_MASK: rd_val = {5'h00, int_mask_r};
			pcp_pkg::OFF_P3_DATA:  rd_val = {5'h00, p3_data_r};
			pcp_pkg::OFF_P3_PINS:  rd_val = {4'h0, p2_pin_val[0] & 1'b0, p3_smp_r[2] & ~analog, p3_smp_r[1:0]};
			pcp_pkg::OFF_SER_CTRL: rd_val = ser_ctrl_r;
			pcp_pkg::OFF_SMR:      rd_val = smr_r;
			default:               rd_ok  = 1'b0;
		endcase
		if (paddr[31:8] != 24'h000000) begin
			rd_ok = 1'b0;
		end
	end

	// Read data captured in the setup cycle, valid through the access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (setup && !pwrite) begin
			prdata <= {24'h000000, rd_ok ? rd_val : pcp_pkg::RST_BYTE};
		end
	end

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			p2_data_r  <= pcp_pkg::RST_BYTE;
			p2_dir_r   <= pcp_pkg::RST_BYTE;
			p3_mode_r  <= pcp_pkg::RST_BYTE;
			pcfg_r     <= pcp_pkg::RST_BYTE;
			irq_req_r  <= pcp_pkg::RST_BYTE;
			ser_ctrl_r <= pcp_pkg::RST_BYTE;
			smr_r      <= pcp_pkg::RST_BYTE;
			p3_data_r  <= pcp_pkg::RST_P3;
			int_mask_r <= pcp_pkg::RST_INT;
		end else if (wr_en && rd_ok) begin
			case (paddr[7:0])
				pcp_pkg::OFF_P2_DATA:  p2_data_r  <= pwdata[7:0];
				pcp_pkg::OFF_P2_DIR:   p2_dir_r   <= pwdata[7:0];
				pcp_pkg::OFF_P3_MODE:  p3_mode_r  <= pwdata[7:0];
				pcp_pkg::OFF_PCFG:     pcfg_r     <= pwdata[7:0];
				pcp_pkg::OFF_IRQ_REQ:  irq_req_r  <= pwdata[7:0];
				pcp_pkg::OFF_INT_MASK: int_mask_r <= pwdata[pcp_pkg::INT_W-1:0];
				pcp_pkg::OFF_P3_DATA:  p3_data_r  <= pwdata[pcp_pkg::P3_W-1:0];
				pcp_pkg::OFF_SER_CTRL: ser_ctrl_r <= pwdata[7:0];
				pcp_pkg::OFF_SMR:      smr_r      <= pwdata[7:0];
				default:               p2_data_r  <= p2_data_r;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Low emission and clock selects
	// ----------------------------------------------------------------
	assign low_emi_port2 = pcfg_r[pcp_pkg::PCFG_EMI_P2];
	assign low_emi_port3 = pcfg_r[pcp_pkg::PCFG_EMI_P3];
	assign low_emi_osc   = pcfg_r[pcp_pkg::PCFG_EMI_OSC];
	assign ext_clock_sel = smr_r[pcp_pkg::SMR_EXT_CLK];

	// ----------------------------------------------------------------
	// Port 2 pins
	// ----------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < pcp_pkg::P2_W; i++) begin
			p2_out_nxt[i]  = p2_data_r[i];
			p2_drv_mine[i] = p2_dir_r[i] & ~(open_drain & p2_data_r[i]);
		end
		if (ser_en) begin
			p2_drv_mine[0] = 1'b0;
			p2_out_nxt[7]  = serial_data_out;
			p2_drv_mine[7] = ~(open_drain & serial_data_out);
		end
		p2_oe_n_nxt = ~p2_drv_mine;
		p2_pin_val  = (p2_drv_mine & p2_out_nxt) | (~p2_drv_mine & p2_in);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			p2_out  <= pcp_pkg::RST_BYTE;
			p2_oe_n <= 8'hFF;
		end else begin
			p2_out  <= p2_out_nxt;
			p2_oe_n <= p2_oe_n_nxt;
		end
	end

	pcp_keeper #(
		.W (pcp_pkg::P2_W)
	) u_keep (
		.pclk    (pclk),
		.presetn (presetn),
		.pin     (p2_pin_val),
		.driven  (p2_ext_drv | p2_drv_mine),
		.held_r  (p2_held)
	);

	// ----------------------------------------------------------------
	// Port 3 inputs and comparators
	// ----------------------------------------------------------------
	assign cmp_enable = analog;

	// Plain CMOS inputs, no keeper; analog mode uses comparator results
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			p3_smp_r <= pcp_pkg::RST_P3;
		end else begin
			p3_smp_r[0] <= analog ? cmp_out[0] : p3_in[0];
			p3_smp_r[1] <= analog ? cmp_out[1] : p3_in[1];
			p3_smp_r[2] <= p3_in[2];
		end
	end

	assign timer_input_pin   = p3_smp_r[0];
	assign ev31.lvl          = p3_smp_r[0];
	assign ev32.lvl          = p3_smp_r[1];
	assign ev33.lvl          = p3_smp_r[2];

	pcp_edge u_e31 (.pclk (pclk), .presetn (presetn), .ev (ev31));
	pcp_edge u_e32 (.pclk (pclk), .presetn (presetn), .ev (ev32));
	pcp_edge u_e33 (.pclk (pclk), .presetn (presetn), .ev (ev33));

	// ----------------------------------------------------------------
	// Interrupt events
	// ----------------------------------------------------------------
	always_comb begin
		case (pcp_pkg::pcp_edge_t'(edge_sel))
			pcp_pkg::PCP_EDGE_FALL: begin
				evt[pcp_pkg::INT_P31] = ev31.fall;
				evt[pcp_pkg::INT_P32] = ev32.fall;
			end
			pcp_pkg::PCP_EDGE_RISE: begin
				evt[pcp_pkg::INT_P31] = ev31.rise;
				evt[pcp_pkg::INT_P32] = ev32.rise;
			end
			default: begin
				evt[pcp_pkg::INT_P31] = ev31.rise | ev31.fall;
				evt[pcp_pkg::INT_P32] = ev32.rise | ev32.fall;
			end
		endcase
		evt[pcp_pkg::INT_P33] = ev33.fall & ~analog;
	end

	assign ext_falling_int_1 = evt[pcp_pkg::INT_P33];

	// Set wins over a same-cycle write-one clear
	always_comb begin
		int_stat_nxt = int_stat_r;
		if (wr_en && paddr == {24'h000000, pcp_pkg::OFF_INT_STAT}) begin
			int_stat_nxt = int_stat_r & ~pwdata[pcp_pkg::INT_W-1:0];
		end
		int_stat_nxt = int_stat_nxt | evt;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_stat_r <= pcp_pkg::RST_INT;
		end else begin
			int_stat_r <= int_stat_nxt;
		end
	end

	assign irq = |(int_stat_r & int_mask_r);

	// ----------------------------------------------------------------
	// Port 3 outputs and serial takeover
	// ----------------------------------------------------------------
	assign serial_enable = ser_en;
	assign serial_slave  = ser_slv;

	always_comb begin
		p3_oe_n_nxt = 2'h0;
		p3_out_nxt  = p3_data_r;
		if (pcfg_r[pcp_pkg::PCFG_CMP_OUT]) begin
			p3_out_nxt[1:0] = cmp_out;
		end
		if (ser_en) begin
			p3_out_nxt[0]  = serial_clock_out;
			p3_oe_n_nxt[0] = ser_slv;
			p3_oe_n_nxt[1] = ser_slv;
		end
		if (ser_ctrl_r[pcp_pkg::SER_TMR_OUT]) begin
			p3_out_nxt[2] = timer_output_pin;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			p3_out          <= pcp_pkg::RST_P3;
			p3_oe_n         <= 2'h0;
			serial_data_in  <= 1'b0;
			serial_clock_in <= 1'b0;
			slave_select    <= 1'b1;
		end else begin
			p3_out          <= p3_out_nxt;
			p3_oe_n         <= p3_oe_n_nxt;
			serial_data_in  <= ser_en ? p2_held[0] : 1'b0;
			serial_clock_in <= (ser_en & ser_slv) ? p3_bit4_in : 1'b0;
			slave_select    <= (ser_en & ser_slv) ? p3_bit5_in : 1'b1;
		end
	end
endmodule
`default_nettype wire

/* testbench/pcp_pin_model.sv */
// Far side of the port 2 pads: external drivers and floating lines.
// Assumes it shares pclk with the pin controller.
`timescale 1ns/10ps
`default_nettype none
module pcp_pin_model (
	input  wire logic       pclk,
	input  wire logic [7:0] p2_out,
	input  wire logic [7:0] p2_oe_n,
	input  wire logic [7:0] ext_en,
	input  wire logic [7:0] ext_val,
	output var  logic [7:0] p2_in,
	output var  logic [7:0] p2_ext_drv
);
	logic [7:0] last_r = 8'h00;
	// Own drive first, then the outside driver, else a floating pad that never holds still
	always_comb begin
		p2_in      = (~p2_oe_n & p2_out) | (p2_oe_n & ext_en & ext_val) | (p2_oe_n & ~ext_en & ~last_r);
		p2_ext_drv = ext_en & p2_oe_n;
	end
	always_ff @(posedge pclk) begin
		last_r <= p2_in;
	end
endmodule
`default_nettype wire

/* testbench/pcp_top_sva.sv */
// Checker of drive modes, pin takeover and edge events at the pin controller ports.
// Assumes it is bound into pcp_top and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module pcp_top_sva (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [7:0]  p2_in,
	input wire logic [7:0]  p2_ext_drv,
	input wire logic [7:0]  p2_out,
	input wire logic [7:0]  p2_oe_n,
	input wire logic [2:0]  p3_in,
	input wire logic        p3_bit4_in,
	input wire logic        p3_bit5_in,
	input wire logic [2:0]  p3_out,
	input wire logic [1:0]  p3_oe_n,
	input wire logic [1:0]  cmp_out,
	input wire logic        cmp_enable,
	input wire logic        serial_data_out,
	input wire logic        serial_clock_out,
	input wire logic        serial_data_in,
	input wire logic        serial_clock_in,
	input wire logic        slave_select,
	input wire logic        serial_enable,
	input wire logic        serial_slave,
	input wire logic        timer_output_pin,
	input wire logic        timer_input_pin,
	input wire logic        ext_falling_int_1
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ----------------------------------------------------------------
	// Shadow of written control bits
	// ----------------------------------------------------------------
	logic      od_r;
	logic      an_r;
	logic      rt_r;
	logic      to_r;
	wire logic wr = psel && penable && pwrite;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{od_r, an_r, rt_r, to_r} <= 4'h0;
		end else if (wr) begin
			if (paddr == {24'h0, pcp_pkg::OFF_P3_MODE}) begin
				{an_r, od_r} <= pwdata[1:0];
			end
			if (paddr == {24'h0, pcp_pkg::OFF_PCFG}) begin
				rt_r <= pwdata[pcp_pkg::PCFG_CMP_OUT];
			end
			if (paddr == {24'h0, pcp_pkg::OFF_SER_CTRL}) begin
				to_r <= pwdata[pcp_pkg::SER_TMR_OUT];
			end
		end
	end
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	sequence ser_on_s;
		serial_enable && $past(serial_enable);
	endsequence
	sequence slave_on_s;
		ser_on_s ##0 (serial_slave && $past(serial_slave));
	endsequence
	od_drive_a: assert property (od_r && $past(od_r) && !serial_enable && !$past(serial_enable) |->
		(~p2_oe_n & p2_out) == 8'h00) else $error("open-drain line driven high");
	analog_en_a: assert property (cmp_enable == an_r) else $error("comparator enable wrong");
	p33_fall_a: assert property (!cmp_enable && $fell(p3_in[2]) |-> ##[0:2] ext_falling_int_1)
		else $error("falling edge event missing");
	p33_analog_a: assert property (cmp_enable && $past(cmp_enable, 3) |-> !ext_falling_int_1)
		else $error("event in analog mode");
	route_cmp_a: assert property (rt_r && $past(rt_r) && !serial_enable && !$past(serial_enable) |->
		p3_out[1:0] == $past(cmp_out) && p3_oe_n == 2'h0) else $error("comparator routing wrong");
	ser_din_a: assert property (ser_on_s ##0 $past(p2_ext_drv[0], 2) |->
		p2_oe_n[0] && serial_data_in == $past(p2_in[0], 2)) else $error("serial data in wrong");
	ser_dout_a: assert property (ser_on_s ##0 (!od_r && !$past(od_r)) |->
		!p2_oe_n[7] && p2_out[7] == $past(serial_data_out))
		else $error("serial data out wrong");
	slave_pin_a: assert property (slave_on_s |-> p3_oe_n == 2'h3 && slave_select == $past(p3_bit5_in) &&
		serial_clock_in == $past(p3_bit4_in)) else $error("slave pins wrong");
	master_clk_a: assert property (ser_on_s ##0 (!serial_slave && !$past(serial_slave)) |->
		p3_out[0] == $past(serial_clock_out) && !p3_oe_n[0]) else $error("serial clock out wrong");
	tmr_in_a: assert property (!cmp_enable && !$past(cmp_enable) |-> timer_input_pin == $past(p3_in[0]))
		else $error("timer input wrong");
	tmr_out_a: assert property (to_r && $past(to_r) |-> p3_out[2] == $past(timer_output_pin))
		else $error("timer output wrong");
endmodule
bind pcp_top pcp_top_sva u_pcp_top_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .p2_in, .p2_ext_drv,
	.p2_out, .p2_oe_n, .p3_in, .p3_bit4_in, .p3_bit5_in, .p3_out, .p3_oe_n, .cmp_out, .cmp_enable,
	.serial_data_out, .serial_clock_out, .serial_data_in, .serial_clock_in, .slave_select, .serial_enable,
	.serial_slave, .timer_output_pin, .timer_input_pin, .ext_falling_int_1);
`default_nettype wire

/* testbench/dual_port_pin_control_tb.sv */
// Self-checking bench of the pin controller over APB.
// Assumes the pad model and the bound checker compile beside it.
`timescale 1ns/10ps
`default_nettype none
module dual_port_pin_control_tb;
	typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] q; logic e; logic [6:0] f;} pcp_row_t;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic [31:0] paddr, pwdata, prdata, q;
	logic [7:0]  p2_in, p2_ext_drv, p2_out, p2_oe_n, ext_en, ext_val;
	logic [2:0]  p3_in, p3_out;
	logic [1:0]  p3_oe_n, cmp_out;
	logic        p3_bit4_in, p3_bit5_in, cmp_enable, serial_data_out, serial_clock_out, serial_data_in;
	logic        serial_clock_in, slave_select, serial_enable, serial_slave, timer_output_pin, timer_input_pin;
	logic        ext_falling_int_1, low_emi_port2, low_emi_port3, low_emi_osc, ext_clock_sel, irq;
	int          n_errors, check_count;
	pcp_row_t    rows [9] = '{'{pcp_pkg::OFF_PCFG, 8'h0E, 8'h0E, 1'b0, 7'h70},
		'{pcp_pkg::OFF_PCFG, 8'h04, 8'h04, 1'b0, 7'h20}, '{pcp_pkg::OFF_PCFG, 8'h08, 8'h08, 1'b0, 7'h10},
		'{pcp_pkg::OFF_SMR, 8'h02, 8'h02, 1'b0, 7'h18}, '{pcp_pkg::OFF_P3_MODE, 8'h02, 8'h02, 1'b0, 7'h19},
		'{pcp_pkg::OFF_SER_CTRL, 8'h03, 8'h03, 1'b0, 7'h1F}, '{pcp_pkg::OFF_SER_CTRL, 8'h00, 8'h00, 1'b0, 7'h19},
		'{pcp_pkg::OFF_P3_MODE, 8'h00, 8'h00, 1'b0, 7'h18}, '{8'h30, 8'h55, 8'h00, 1'b1, 7'h18}};
	pcp_top u_pcp_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.p2_in, .p2_ext_drv, .p2_out, .p2_oe_n, .p3_in, .p3_bit4_in, .p3_bit5_in, .p3_out, .p3_oe_n, .cmp_out,
		.cmp_enable, .serial_data_out, .serial_clock_out, .serial_data_in, .serial_clock_in, .slave_select,
		.serial_enable, .serial_slave, .timer_output_pin, .timer_input_pin, .ext_falling_int_1, .low_emi_port2,
		.low_emi_port3, .low_emi_osc, .ext_clock_sel, .irq);
	pcp_pin_model u_pcp_pin_model (.pclk, .p2_out, .p2_oe_n, .ext_en, .ext_val, .p2_in, .p2_ext_drv);
	// ----------------------------------------------------------------
	// Clock, bus tasks and checks
	// ----------------------------------------------------------------
	// System clock only; no low-emission crystal path is modelled
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		check_count++;
		if (s !== x) begin
			n_errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, s, x);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, 24'h0, a, 24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		q = prdata;
		e = pslverr;
		{psel, penable} <= 2'h0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] x);
		apb(1'b0, a, 8'h00);
		chk(q, {24'h0, x});
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic stop_test;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge pclk);
		n_errors++;
		stop_test();
	end
	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		{presetn, psel, penable, pwrite, p3_bit4_in, p3_bit5_in, serial_data_out, serial_clock_out} = '0;
		{timer_output_pin, paddr, pwdata, ext_en, ext_val, p3_in, cmp_out} = '0;
		{n_errors, check_count} = '0;
		repeat (4) @(posedge pclk);
		chk({24'h0, p2_oe_n}, 32'hFF);
		chk({28'h0, slave_select, p3_oe_n, irq}, 32'h8);
		presetn <= 1'b1;
		foreach (rows[i]) begin
			apb(1'b1, rows[i].a, rows[i].d);
			rd(rows[i].a, rows[i].q);
			chk({31'h0, e}, {31'h0, rows[i].e});
			chk({25'h0, low_emi_port2, low_emi_port3, low_emi_osc, ext_clock_sel, serial_enable, serial_slave,
				cmp_enable}, {25'h0, rows[i].f});
		end
		$display("registers done");
		apb(1'b1, pcp_pkg::OFF_P2_DATA, 8'h5A);
		apb(1'b1, pcp_pkg::OFF_P2_DIR, 8'h0F);
		rd(pcp_pkg::OFF_P2_DIR, 8'h0F);
		chk({20'h0, p2_oe_n, p2_out[3:0]}, 32'hF0A);
		apb(1'b1, pcp_pkg::OFF_P3_MODE, 8'h01);
		wt(2);
		chk({24'h0, p2_oe_n}, 32'hFA);
		apb(1'b1, pcp_pkg::OFF_P3_MODE, 8'h00);
		ext_en <= 8'hF0;
		ext_val <= 8'h90;
		wt(3);
		rd(pcp_pkg::OFF_P2_PINS, 8'h9A);
		ext_en <= 8'h00;
		wt(3);
		rd(pcp_pkg::OFF_P2_PINS, 8'h9A);
		$display("port2 done");
		apb(1'b1, pcp_pkg::OFF_INT_MASK, 8'h05);
		for (int m = 0; m < 4; m++) begin
			apb(1'b1, pcp_pkg::OFF_IRQ_REQ, 8'(m << 6));
			apb(1'b1, pcp_pkg::OFF_INT_STAT, 8'h07);
			p3_in <= 3'h3;
			wt(4);
			rd(pcp_pkg::OFF_INT_STAT, (m != 0) ? 8'h05 : 8'h00);
			chk({30'h0, irq, timer_input_pin}, {30'h0, m != 0, 1'b1});
			apb(1'b1, pcp_pkg::OFF_INT_STAT, 8'h07);
			p3_in <= 3'h0;
			wt(4);
			rd(pcp_pkg::OFF_INT_STAT, (m != 1) ? 8'h05 : 8'h00);
		end
		apb(1'b1, pcp_pkg::OFF_INT_MASK, 8'h00);
		wt(1);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, pcp_pkg::OFF_INT_STAT, 8'h07);
		p3_in <= 3'h4;
		wt(4);
		rd(pcp_pkg::OFF_INT_STAT, 8'h00);
		rd(pcp_pkg::OFF_P3_PINS, 8'h04);
		p3_in <= 3'h0;
		wt(4);
		rd(pcp_pkg::OFF_INT_STAT, 8'h02);
		apb(1'b1, pcp_pkg::OFF_INT_STAT, 8'h07);
		apb(1'b1, pcp_pkg::OFF_P3_MODE, 8'h02);
		p3_in <= 3'h4;
		cmp_out <= 2'h1;
		wt(4);
		p3_in <= 3'h0;
		wt(4);
		rd(pcp_pkg::OFF_INT_STAT, 8'h04);
		rd(pcp_pkg::OFF_P3_PINS, 8'h01);
		chk({31'h0, timer_input_pin}, 32'h1);
		apb(1'b1, pcp_pkg::OFF_P3_MODE, 8'h00);
		$display("events done");
		apb(1'b1, pcp_pkg::OFF_PCFG, 8'h01);
		cmp_out <= 2'h2;
		wt(3);
		chk({28'h0, p3_out[1:0], p3_oe_n}, 32'h8);
		apb(1'b1, pcp_pkg::OFF_PCFG, 8'h00);
		apb(1'b1, pcp_pkg::OFF_P3_DATA, 8'h00);
		{ext_en, ext_val, serial_data_out, serial_clock_out, timer_output_pin, p3_bit4_in} <= {8'h01, 8'h01, 4'hF};
		apb(1'b1, pcp_pkg::OFF_SER_CTRL, 8'h01);
		wt(4);
		chk({27'h0, serial_data_in, p2_oe_n[7], p2_oe_n[0], p2_out[7]}, 32'hB);
		chk({29'h0, p3_out}, 32'h1);
		apb(1'b1, pcp_pkg::OFF_SER_CTRL, 8'h07);
		wt(3);
		chk({27'h0, p3_oe_n, slave_select, serial_clock_in, p3_out[2]}, 32'h1B);
		$display("pins done");
		stop_test();
	end
endmodule
`default_nettype wire
